// >>> rtst_seconds_trim.sv
`timescale 1ns/1ps
`include "rtst_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
module rtst_seconds_trim
  import rtst_pkg::*;
#(
  parameter int unsigned TICKS_PER_SEC = `RTST_XTAL_HZ
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       xtal_tick,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_ack,
  output logic            second_pulse
);
  //////////////////////////////////////////////////////////////////////////////
  // Input synchroniser for the crystal tick, which is off this clock.
  logic tick_m;
  logic tick_s;
  logic tick_d;
  logic tick_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_m <= 1'b0;
      tick_s <= 1'b0;
      tick_d <= 1'b0;
    end else begin
      tick_m <= xtal_tick;
      tick_s <= tick_m;
      tick_d <= tick_s;
    end
  end
  assign tick_rise = tick_s && !tick_d;

  //////////////////////////////////////////////////////////////////////////////
  // Register decode.
  rtst_sel_e sel;
  always_comb begin
    case (reg_addr)
      `RTST_OFF_CTRL: sel = RTST_SEL_CTRL;
      `RTST_OFF_TRIM: sel = RTST_SEL_TRIM;
      `RTST_OFF_SEC:  sel = RTST_SEL_SEC;
      default:        sel = RTST_SEL_NONE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and trim registers.
  logic [7:0]  ctrl;
  logic [7:0]  trim;
  logic [7:0]  next_ctrl;
  logic [7:0]  next_trim;
  logic        trim_mode;
  logic        halted;
  logic        freeze;
  logic        wr_ctrl;
  logic        wr_trim;
  logic        wr_sec;

  assign trim_mode = ctrl[`RTST_CTRL_TRIM];
  assign halted    = ctrl[`RTST_CTRL_HALT];
  assign freeze    = ctrl[`RTST_CTRL_WRITE];
  assign wr_ctrl   = reg_wr && (sel == RTST_SEL_CTRL);
  assign wr_trim   = reg_wr && (sel == RTST_SEL_TRIM);
  assign wr_sec    = reg_wr && (sel == RTST_SEL_SEC);

  // Reserved bit 3 always reads zero; trim bits gated by trim mode.
  always_comb begin
    next_ctrl = ctrl;
    next_trim = trim;
    if (wr_ctrl) begin
      next_ctrl = reg_wdata & 8'hF7;
    end
    if (wr_trim && trim_mode) begin
      next_trim = reg_wdata & 8'h3F;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `RTST_CTRL_RST;
      trim <= `RTST_TRIM_RST;
    end else begin
      ctrl <= next_ctrl;
      trim <= next_trim;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trimmed timebase: the code scales a tick offset per second.
  logic [15:0] tb_cnt;
  logic [15:0] next_tb_cnt;
  logic [15:0] tb_top;
  logic [15:0] trim_amt;
  logic        sec_tick;

  assign trim_amt = 16'(trim[`RTST_TRIM_CODE_W-1:0]) *
                    `RTST_TRIM_STEP;
  // A set sign bit shortens the second, so the clock runs faster.
  assign tb_top = trim[`RTST_TRIM_SIGN] ?
                  16'(TICKS_PER_SEC - 1) - trim_amt :
                  16'(TICKS_PER_SEC - 1) + trim_amt;
  assign sec_tick = tick_rise && !halted && (tb_cnt >= tb_top);

  always_comb begin
    next_tb_cnt = tb_cnt;
    if (wr_sec) begin
      next_tb_cnt = 16'h0000;
    end else if (tick_rise && !halted) begin
      next_tb_cnt = sec_tick ? 16'h0000 : tb_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tb_cnt <= 16'h0000;
    end else begin
      tb_cnt <= next_tb_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Seconds counter as two BCD digits; writes clamp illegal digits.
  logic [3:0] sec_units;
  logic [3:0] sec_tens;
  logic       units_wrap;
  logic       tens_wrap;
  logic [3:0] ld_units;
  logic [3:0] ld_tens;

  // Out-of-range digits are forced to their top so 59 is never exceeded.
  assign ld_units = (reg_wdata[3:0] > 4'h9) ? 4'h9 : reg_wdata[3:0];
  assign ld_tens  = (reg_wdata[6:4] > 3'h5) ? 4'h5 : {1'b0, reg_wdata[6:4]};

  rtst_bcd_digit #(.TOP(4'h9)) u_units (
    .clk      (clk),
    .rst      (rst),
    .load     (wr_sec),
    .load_val (ld_units),
    .inc      (sec_tick),
    .value    (sec_units),
    .wrap     (units_wrap)
  );

  rtst_bcd_digit #(.TOP(4'h5)) u_tens (
    .clk      (clk),
    .rst      (rst),
    .load     (wr_sec),
    .load_val (ld_tens),
    .inc      (units_wrap),
    .value    (sec_tens),
    .wrap     (tens_wrap)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Capture image: frozen while the read bit is set, so reads stay coherent.
  logic [7:0] sec_img;
  logic [7:0] next_sec_img;
  logic       read_hold;

  assign read_hold = ctrl[`RTST_CTRL_READ];
  always_comb begin
    next_sec_img = sec_img;
    // While the bit is clear the image tracks the digits, so the write
    // that sets it captures the value of that very cycle.
    if (!read_hold) begin
      next_sec_img = {1'b0, sec_tens[2:0], sec_units};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, acknowledge and second pulse, all registered.
  logic [7:0] next_rdata;
  logic       next_pulse;

  always_comb begin
    case (sel)
      RTST_SEL_CTRL: next_rdata = ctrl;
      RTST_SEL_TRIM: next_rdata = trim;
      RTST_SEL_SEC:  next_rdata = sec_img;
      default:       next_rdata = 8'h00;
    endcase
    if (!reg_rd) begin
      next_rdata = reg_rdata;
    end
    next_pulse = sec_tick && !freeze;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_img      <= `RTST_SEC_RST;
      reg_rdata    <= 8'h00;
      reg_ack      <= 1'b0;
      second_pulse <= 1'b0;
    end else begin
      sec_img      <= next_sec_img;
      reg_rdata    <= next_rdata;
      reg_ack      <= reg_wr || reg_rd;
      second_pulse <= next_pulse;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence trim_write_s;
    wr_trim && trim_mode;
  endsequence

  sec_range_a: assert property (@(posedge clk) disable iff (rst)
    (sec_tens <= 4'h5) && (sec_units <= 4'h9))
    else $error("seconds out of BCD range");

  tens_carry_a: assert property (@(posedge clk) disable iff (rst)
    (sec_tick && !wr_sec && sec_units == 4'h9 && sec_tens != 4'h5)
      |=> (sec_units == 4'h0) && (sec_tens == $past(sec_tens) + 4'h1))
    else $error("units wrap did not carry");

  sec_wrap_a: assert property (@(posedge clk) disable iff (rst)
    (sec_tick && !wr_sec && sec_units == 4'h9 && sec_tens == 4'h5)
      |=> (sec_units == 4'h0) && (sec_tens == 4'h0))
    else $error("59 did not wrap to 00");

  trim_lock_a: assert property (@(posedge clk) disable iff (rst)
    (!(wr_trim && trim_mode)) |=> $stable(trim))
    else $error("trim changed outside trim mode");

  trim_load_a: assert property (@(posedge clk) disable iff (rst)
    trim_write_s |=> (trim[4:0] == $past(reg_wdata[4:0])))
    else $error("trim code not written");

  trim_sign_a: assert property (@(posedge clk) disable iff (rst)
    (tick_rise && !halted && !wr_sec && trim[`RTST_TRIM_SIGN] &&
     (tb_cnt + trim_amt == 16'(TICKS_PER_SEC - 1))) |-> sec_tick)
    else $error("sign did not shorten the second");
endmodule // rtst_seconds_trim

// >>> rtst_cfg.svh
`ifndef RTST_CFG_SVH
`define RTST_CFG_SVH
// Register offsets.
`define RTST_OFF_CTRL      8'h00
`define RTST_OFF_TRIM      8'h01
`define RTST_OFF_SEC       8'h02
// Control register bit positions.
`define RTST_CTRL_HALT     7
`define RTST_CTRL_AFLAG    6
`define RTST_CTRL_CFLAG    5
`define RTST_CTRL_AEN      4
`define RTST_CTRL_TRIM     2
`define RTST_CTRL_WRITE    1
`define RTST_CTRL_READ     0
// Trim register fields.
`define RTST_TRIM_SIGN     5
`define RTST_TRIM_CODE_W   5
// Reset values.
`define RTST_CTRL_RST      8'h00
`define RTST_TRIM_RST      8'h00
`define RTST_SEC_RST       8'h00
// Timebase: crystal ticks per second and nominal trim step in ticks.
`define RTST_XTAL_HZ       32768
`define RTST_TRIM_STEP     16'h0002
`endif

// >>> rtst_pkg.sv
package rtst_pkg;
  typedef logic [7:0] rtst_byte_t;
  typedef enum logic [1:0] {
    RTST_SEL_CTRL = 2'b00,
    RTST_SEL_TRIM = 2'b01,
    RTST_SEL_SEC  = 2'b10,
    RTST_SEL_NONE = 2'b11
  } rtst_sel_e;
endpackage

// >>> rtst_bcd_digit.sv
`timescale 1ns/1ps
// One BCD digit with load, increment and a programmable top value.
module rtst_bcd_digit
  import rtst_pkg::*;
#(
  parameter logic [3:0] TOP = 4'h9
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [3:0] load_val,
  input  wire logic       inc,
  output logic [3:0]      value,
  output logic            wrap
);
  logic [3:0] next_value;

  // Wrap is combinational so the next digit steps in the same cycle.
  assign wrap = inc && (value == TOP);

  // Load wins over counting so a host write is never lost.
  always_comb begin
    next_value = value;
    if (load) begin
      next_value = load_val;
    end else if (inc) begin
      next_value = (value >= TOP) ? 4'h0 : value + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value <= 4'h0;
    end else begin
      value <= next_value;
    end
  end
endmodule // rtst_bcd_digit

// >>> rtst_host_model.sv
`timescale 1ns/1ps
// Host side of the register strobes, plus the crystal square wave.
module rtst_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_ack,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            xtal_tick
);
  // Idle levels from time zero so nothing unknown reaches the block.
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    xtal_tick = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // One byte access; the strobe lasts one cycle as the block expects.
  // Address and data are inverted once released, so a stale value is
  // never mistaken for a live one.
  task automatic access(input logic wr, input logic [7:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
    int n;
    rdata = 8'hXX;
    @(posedge clk);
    #1;
    reg_addr  = addr;
    reg_wdata = wdata;
    reg_wr    = wr;
    reg_rd    = !wr;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~wdata;
    for (n = 0; n < 4; n++) begin
      @(posedge clk);
      if (reg_ack === 1'b1) begin
        rdata = reg_rdata;
        break;
      end
    end
  endtask
  // Crystal ticks, far faster than real so the run stays short.
  task automatic ticks(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk);
      #1 xtal_tick = 1'b1;
      repeat (3) @(posedge clk);
      #1 xtal_tick = 1'b0;
    end
  endtask
endmodule // rtst_host_model

// >>> rtst_seconds_trim_test.sv
`timescale 1ns/1ps
`include "rtst_cfg.svh"
module rtst_seconds_trim_test
  import rtst_pkg::*;
;
  localparam int unsigned TPS = 64;
  logic       clk;
  logic       rst;
  logic       reg_wr;
  logic       reg_rd;
  logic       xtal_tick;
  logic       reg_ack;
  logic       second_pulse;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] rd;
  int         bad_count = 0;
  int         checks = 0;
  int         cycles = 0;
  int         pulses = 0;
  rtst_seconds_trim #(.TICKS_PER_SEC(TPS)) i_rtst_seconds_trim (
    .clk(clk), .rst(rst), .xtal_tick(xtal_tick), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .second_pulse(second_pulse));
  rtst_host_model i_rtst_host_model (
    .clk(clk), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .xtal_tick(xtal_tick));
  // 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Rollover pulses and the hang guard share one process; the falling
  // edge sees each one-cycle pulse once, clear of the launching edge.
  always @(negedge clk) begin
    cycles++;
    if (second_pulse === 1'b1) pulses++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_rtst_host_model.access(1'b1, a, d, rd);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_rtst_host_model.access(1'b0, a, 8'h00, rd);
    check(rd, exp);
  endtask
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // The trim byte is locked unless trim mode is on, and locks again after.
  task automatic test_trim_lock();
    rd_chk(`RTST_OFF_TRIM, 8'h00);
    wr(`RTST_OFF_TRIM, 8'h3F);
    rd_chk(`RTST_OFF_TRIM, 8'h00);
    wr(`RTST_OFF_CTRL, 8'h04);
    rd_chk(`RTST_OFF_CTRL, 8'h04);
    wr(`RTST_OFF_TRIM, 8'h3F);
    rd_chk(`RTST_OFF_TRIM, 8'h3F);
    wr(`RTST_OFF_CTRL, 8'h00);
    wr(`RTST_OFF_TRIM, 8'h00);
    rd_chk(`RTST_OFF_TRIM, 8'h3F);
  endtask
  // Out-of-range BCD is clamped, so the register never exceeds 59.
  task automatic test_clamp();
    rd_chk(`RTST_OFF_SEC, 8'h00);
    wr(`RTST_OFF_SEC, 8'h7F);
    rd_chk(`RTST_OFF_SEC, 8'h59);
  endtask
  // Negative sign shortens the second by two ticks per code unit; the
  // early read alone would pass with no trim at all, hence the last-tick check.
  task automatic test_fast();
    wr(`RTST_OFF_CTRL, 8'h04);
    wr(`RTST_OFF_TRIM, 8'h21);
    wr(`RTST_OFF_SEC, 8'h59);
    i_rtst_host_model.ticks(TPS - 3);
    repeat (4) @(posedge clk);
    rd_chk(`RTST_OFF_SEC, 8'h59);
    i_rtst_host_model.ticks(1);
    repeat (4) @(posedge clk);
    rd_chk(`RTST_OFF_SEC, 8'h00);
  endtask
  // Positive sign lengthens the second; the units digit carries into tens.
  task automatic test_slow();
    wr(`RTST_OFF_TRIM, 8'h01);
    wr(`RTST_OFF_SEC, 8'h09);
    i_rtst_host_model.ticks(TPS + 1);
    repeat (4) @(posedge clk);
    rd_chk(`RTST_OFF_SEC, 8'h09);
    i_rtst_host_model.ticks(1);
    repeat (4) @(posedge clk);
    rd_chk(`RTST_OFF_SEC, 8'h10);
    check(pulses[7:0], 8'h02);
  endtask
  // Capture image, halt and the pulse freeze, each set once.
  task automatic test_hold();
    wr(`RTST_OFF_CTRL, 8'h01);
    wr(`RTST_OFF_SEC, 8'h20);
    rd_chk(`RTST_OFF_SEC, 8'h10);
    wr(`RTST_OFF_CTRL, 8'h80);
    i_rtst_host_model.ticks(TPS + 4);
    repeat (4) @(posedge clk);
    rd_chk(`RTST_OFF_SEC, 8'h20);
    wr(`RTST_OFF_CTRL, 8'h02);
    i_rtst_host_model.ticks(TPS + 2);
    repeat (4) @(posedge clk);
    rd_chk(`RTST_OFF_SEC, 8'h21);
    check(pulses[7:0], 8'h02);
  endtask
  // Reset held four cycles, then the scenarios in turn.
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    test_trim_lock();
    test_clamp();
    test_fast();
    test_slow();
    test_hold();
    finish_test();
  end
endmodule // rtst_seconds_trim_test
